// ### hdl/dtr_consts.svh
// constants for the dram timing and refresh controller
// assumes a 25 MHz system clock (40 ns period)
`ifndef DTR_CONSTS_SVH
`define DTR_CONSTS_SVH
`define DTR_CLK_PERIOD_NS   40
`define DTR_COL_DELAY_NS    30
`define DTR_RAS_WIDTH_NS    150
`define DTR_TAIL_NS         150
`define DTR_REFRESH_HZ      80000
// least times round up, at least one cycle
`define DTR_COL_CYC   ((`DTR_COL_DELAY_NS + `DTR_CLK_PERIOD_NS - 1) / `DTR_CLK_PERIOD_NS)
`define DTR_RAS_CYC   ((`DTR_RAS_WIDTH_NS + `DTR_CLK_PERIOD_NS - 1) / `DTR_CLK_PERIOD_NS)
`define DTR_TAIL_CYC  ((`DTR_TAIL_NS + `DTR_CLK_PERIOD_NS - 1) / `DTR_CLK_PERIOD_NS)
// refresh tick divider: 25 MHz / 80 kHz
`define DTR_TICK_CYC  (25000000 / `DTR_REFRESH_HZ)
`define DTR_RAS_SEL_POS 0
`endif

// ### hdl/dtr_pkg.sv
// types for the dram timing and refresh controller
// used by the timing chain; the controller top does not import it
package dtr_pkg;
    typedef enum logic [2:0] {
        DTR_IDLE,
        DTR_ROW,
        DTR_COL,
        DTR_RAS_OFF,
        DTR_TAIL
    } dtr_phase_t;
    typedef logic [8:0] dtr_maddr_t;
endpackage

// ### hdl/dtr_chain.sv
// timing chain: ras pulse, column select and trailing recovery interval
// assumes start is held or dropped freely; the chain latches it itself
`timescale 1ns/1ps
module dtr_chain (
    input  wire logic clk_i,      // system clock
    input  wire logic sys_rst_i,  // synchronous reset
    input  wire logic start_i,    // cycle request
    output logic      ras_o,      // ras active (high = asserted)
    output logic      colsel_o,   // row/column select
    output logic      col_rise_o, // one-cycle pulse on select rising
    output logic      busy_o      // chain not ready for a new cycle
);
`include "dtr_consts.svh"
    dtr_pkg::dtr_phase_t phase_q;
    logic [7:0]          cnt_q;

    // phase sequence; once started, runs to the end regardless of start
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            phase_q <= dtr_pkg::DTR_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            case (phase_q)
                dtr_pkg::DTR_IDLE: begin
                    if (start_i) begin
                        phase_q <= dtr_pkg::DTR_ROW;
                        cnt_q   <= 8'h01;
                    end
                end
                dtr_pkg::DTR_ROW: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(`DTR_COL_CYC)) begin
                        phase_q <= dtr_pkg::DTR_COL;
                    end
                end
                dtr_pkg::DTR_COL: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(`DTR_RAS_CYC)) begin
                        phase_q <= dtr_pkg::DTR_RAS_OFF;
                        cnt_q   <= 8'h01;
                    end
                end
                dtr_pkg::DTR_RAS_OFF: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(`DTR_COL_CYC)) begin
                        phase_q <= dtr_pkg::DTR_TAIL;
                    end
                end
                dtr_pkg::DTR_TAIL: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == 8'(`DTR_TAIL_CYC)) begin
                        phase_q <= dtr_pkg::DTR_IDLE;
                        cnt_q   <= 8'h00;
                    end
                end
                default: begin
                    phase_q <= dtr_pkg::DTR_IDLE;
                    cnt_q   <= 8'h00;
                end
            endcase
        end
    end

    // registered outputs decoded from the current phase, one cycle behind it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ras_o      <= 1'b0;
            colsel_o   <= 1'b0;
            col_rise_o <= 1'b0;
            busy_o     <= 1'b0;
        end else begin
            ras_o      <= (phase_q == dtr_pkg::DTR_ROW) || (phase_q == dtr_pkg::DTR_COL);
            colsel_o   <= (phase_q == dtr_pkg::DTR_COL) || (phase_q == dtr_pkg::DTR_RAS_OFF);
            col_rise_o <= (phase_q == dtr_pkg::DTR_COL) && !colsel_o;
            // busy from the start edge on, so a held start cannot retrigger
            busy_o     <= (phase_q != dtr_pkg::DTR_IDLE) || start_i;
        end
    end
endmodule

// ### hdl/dtr_ctrl.sv
// dram timing and refresh controller top: cpu strobes in, dram controls out
// assumes cpu inputs synchronous to clk_i; strobes active low at the pins
`timescale 1ns/1ps
module dtr_ctrl (
    input  wire logic        clk_i,           // system clock
    input  wire logic        sys_rst_i,       // synchronous reset
    input  wire logic        cpu_clock_i,     // cpu clock, sampled
    input  wire logic [23:1] cpu_addr_i,      // cpu address bus
    input  wire logic        as_n_i,          // address strobe
    input  wire logic        uds_n_i,         // upper data strobe
    input  wire logic        lds_n_i,         // lower data strobe
    input  wire logic        rw_i,            // read high, write low
    input  wire logic        dram_sel_n_i,    // dram decoded enable
    input  wire logic        exp_wait_i,      // cpu waiting on expansion card
    output logic [8:0]       mem_addr_o,      // multiplexed dram address
    output logic             ras_n_o,         // row strobe to all drams
    output logic             mem_rw_o,        // read/write to all drams
    output logic             cas_even_low_half_n_o,  // cas even bytes, first half
    output logic             cas_odd_low_half_n_o,   // cas odd bytes, first half
    output logic             cas_even_high_half_n_o, // cas even bytes, second half
    output logic             cas_odd_high_half_n_o,  // cas odd bytes, second half
    output logic             dram_ack_n_o,    // early data acknowledge
    output logic [7:0]       refresh_row_o    // refresh counter value
);
`include "dtr_consts.svh"

    logic        ras_w;
    logic        colsel_w;
    logic        col_rise_w;
    logic        busy_w;
    logic        start_w;
    logic        cpu_cyc_q;
    logic        ref_cyc_q;
    logic        req1_q;
    logic        req2_q;
    logic        ref_go_q;
    logic        cas_latch_q;
    logic        cpuclk_q;
    logic [7:0]  ref_cnt_q;
    logic [15:0] tick_cnt_q;
    logic        tick_w;
    logic        sync_strobe_w;
    logic [8:0]  row_addr_w;
    logic [8:0]  col_addr_w;
    logic [3:0]  grp_w;

    // refresh sync strobe: follows as, forced low during expansion waits
    assign sync_strobe_w = as_n_i & ~exp_wait_i;

    // 80 kHz tick divider
    assign tick_w = (tick_cnt_q == 16'(`DTR_TICK_CYC - 1));
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || tick_w) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // refresh row counter, one row per tick; wraps 256
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ref_cnt_q <= 8'h00;
        end else if (tick_w) begin
            ref_cnt_q <= ref_cnt_q + 8'h01;
        end
    end

    // cpu clock edge detect
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpuclk_q <= 1'b0;
        end else begin
            cpuclk_q <= cpu_clock_i;
        end
    end

    // request chain; cleared the cycle after the select rise in the refresh cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || (ref_cyc_q && col_rise_w)) begin
            req1_q   <= 1'b0;
            req2_q   <= 1'b0;
            ref_go_q <= 1'b0;
        end else begin
            if (tick_w) begin
                req1_q <= 1'b1;
            end
            if (req1_q && cpu_clock_i && !cpuclk_q) begin
                req2_q <= 1'b1;
            end
            if (req2_q && !sync_strobe_w && !cpu_clock_i && cpuclk_q && !cpu_cyc_q) begin
                ref_go_q <= 1'b1;
            end
        end
    end

    // chain start: cpu access or refresh, never while the other is active
    assign start_w = !busy_w && ((!dram_sel_n_i && !ref_go_q) || ref_go_q);

    // cycle-active terms held by feedback until the chain is idle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cpu_cyc_q <= 1'b0;
            ref_cyc_q <= 1'b0;
        end else if (start_w) begin
            cpu_cyc_q <= !ref_go_q;
            ref_cyc_q <= ref_go_q;
        end else if (!busy_w && !start_w && (cpu_cyc_q || ref_cyc_q) && !ras_w) begin
            cpu_cyc_q <= cpu_cyc_q && busy_w;
            ref_cyc_q <= ref_cyc_q && busy_w;
        end
    end

    dtr_chain u_chain (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (start_w),
        .ras_o      (ras_w),
        .colsel_o   (colsel_w),
        .col_rise_o (col_rise_w),
        .busy_o     (busy_w)
    );

    // cas/ack latch: set on select rise in cpu cycle, cleared by as release
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cas_latch_q <= 1'b0;
        end else if (col_rise_w && cpu_cyc_q && !as_n_i) begin
            cas_latch_q <= 1'b1;
        end else if (as_n_i) begin
            cas_latch_q <= 1'b0;
        end
    end

    // fixed permutation of cpu address onto memory address
    assign row_addr_w = {cpu_addr_i[17], cpu_addr_i[9], cpu_addr_i[8], cpu_addr_i[7],
                         cpu_addr_i[4], cpu_addr_i[1], cpu_addr_i[2], cpu_addr_i[3],
                         cpu_addr_i[10]};
    assign col_addr_w = {cpu_addr_i[18], cpu_addr_i[15], cpu_addr_i[14], cpu_addr_i[13],
                         cpu_addr_i[5], cpu_addr_i[6], cpu_addr_i[11], cpu_addr_i[12],
                         cpu_addr_i[16]};

    // group decode: dram space is a23..a20 zero, a19 picks the half
    always_comb begin
        grp_w = 4'h0;
        if (cpu_addr_i[23:20] == 4'h0) begin
            grp_w[0] = !cpu_addr_i[19] && !uds_n_i;
            grp_w[1] = !cpu_addr_i[19] && !lds_n_i;
            grp_w[2] =  cpu_addr_i[19] && !uds_n_i;
            grp_w[3] =  cpu_addr_i[19] && !lds_n_i;
        end
    end

    // registered dram side outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mem_addr_o             <= 9'h000;
            ras_n_o                <= 1'b1;
            mem_rw_o               <= 1'b1;
            cas_even_low_half_n_o  <= 1'b1;
            cas_odd_low_half_n_o   <= 1'b1;
            cas_even_high_half_n_o <= 1'b1;
            cas_odd_high_half_n_o  <= 1'b1;
            dram_ack_n_o           <= 1'b1;
            refresh_row_o          <= 8'h00;
        end else begin
            // only a running refresh owns the bus; a pending one must not
            // corrupt the row of a cpu cycle already under way
            if (ref_cyc_q) begin
                mem_addr_o <= {1'b0, ref_cnt_q};
            end else if (colsel_w) begin
                mem_addr_o <= col_addr_w;
            end else begin
                mem_addr_o <= row_addr_w;
            end
            ras_n_o                <= !ras_w;
            mem_rw_o               <= rw_i;
            cas_even_low_half_n_o  <= !(cas_latch_q && grp_w[0]);
            cas_odd_low_half_n_o   <= !(cas_latch_q && grp_w[1]);
            cas_even_high_half_n_o <= !(cas_latch_q && grp_w[2]);
            cas_odd_high_half_n_o  <= !(cas_latch_q && grp_w[3]);
            dram_ack_n_o           <= !cas_latch_q;
            refresh_row_o          <= ref_cnt_q;
        end
    end

    // checks
    a_ack_with_cas: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cas_even_low_half_n_o |-> !dram_ack_n_o)
        else $error("cas without acknowledge");
    a_no_ack_refresh: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ref_cyc_q |=> !$rose(cas_latch_q))
        else $error("acknowledge set in refresh");
    a_as_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        as_n_i |=> !cas_latch_q)
        else $error("latch not cleared by strobe");
    a_excl_cycles: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(cpu_cyc_q && ref_cyc_q))
        else $error("cpu and refresh both active");
    a_ras_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        start_w |-> ##3 !ras_n_o)
        else $error("ras late");
    a_flags_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ref_cyc_q && col_rise_w |=> !req1_q && !req2_q && !ref_go_q)
        else $error("refresh flags not cleared");
    a_tick_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tick_w |=> ref_cnt_q == $past(ref_cnt_q) + 8'h01)
        else $error("refresh counter stuck");
    a_no_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(ras_n_o) |-> ras_n_o[*4])
        else $error("chain restarted early");
endmodule

// ### verification/dtr_dram_model.sv
// dram array model: row latched on ras fall, column on first cas fall
// assumes registered controller outputs, sampled on the rising edge
`timescale 1ns/1ps
module dtr_dram_model (
    input  wire logic       clk_i,     // system clock
    input  wire logic [8:0] maddr_i,   // multiplexed address
    input  wire logic       ras_n_i,   // row strobe, all chips
    input  wire logic [3:0] cas_n_i,   // four cas groups
    output logic [8:0]      row_o,     // last latched row
    output logic [8:0]      col_o,     // last latched column
    output int              ref_cnt_o  // ras-only cycles seen
);
    logic ras_q = 1'b1;
    logic cas_q = 1'b1;
    logic hit_q = 1'b0;
    initial ref_cnt_o = 0;
    // every chip latches the row; only cas groups take a column
    always @(posedge clk_i) begin
        ras_q <= ras_n_i;
        cas_q <= &cas_n_i;
        if (ras_q && !ras_n_i) begin
            row_o <= maddr_i;
            hit_q <= 1'b0;
        end
        if (cas_q && !(&cas_n_i)) begin
            col_o <= maddr_i;
            hit_q <= 1'b1;
        end
        // a ras pulse with no cas is a refresh
        if (!ras_q && ras_n_i && !hit_q && (&cas_n_i)) ref_cnt_o <= ref_cnt_o + 1;
    end
endmodule

// ### verification/dtr_ctrl_tb.sv
// self-checking bench for the dram timing and refresh controller
// assumes the dram model beside it and a cpu bus driven by tasks here
`timescale 1ns/1ps
module dtr_ctrl_tb;
    logic        clk_i;
    logic        sys_rst_i = 1'b1;
    logic        cpu_clock_i = 1'b0;
    logic [23:1] cpu_addr_i = '0;
    logic        as_n_i = 1'b1;
    logic        uds_n_i = 1'b1;
    logic        lds_n_i = 1'b1;
    logic        rw_i = 1'b1;
    logic        dram_sel_n_i = 1'b1;
    logic        exp_wait_i = 1'b0;
    logic [8:0]  mem_addr_o;
    logic        ras_n_o;
    logic        mem_rw_o;
    logic [3:0]  cas4;
    logic        dram_ack_n_o;
    logic [7:0]  refresh_row_o;
    logic [8:0]  row;
    logic [8:0]  col;
    int          ref_cnt;
    int          fails = 0;
    int          samples_checked = 0;
    logic [31:0] rng = 32'hf757;
    logic [4:0]  exp_q[$];
    logic        ack_q = 1'b1;
    logic [1:0]  ds[3] = '{2'b01, 2'b10, 2'b00};

    dtr_ctrl dut_u (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_clock_i(cpu_clock_i),
        .cpu_addr_i(cpu_addr_i), .as_n_i(as_n_i), .uds_n_i(uds_n_i), .lds_n_i(lds_n_i),
        .rw_i(rw_i), .dram_sel_n_i(dram_sel_n_i), .exp_wait_i(exp_wait_i),
        .mem_addr_o(mem_addr_o), .ras_n_o(ras_n_o), .mem_rw_o(mem_rw_o),
        .cas_even_low_half_n_o(cas4[3]), .cas_odd_low_half_n_o(cas4[2]),
        .cas_even_high_half_n_o(cas4[1]), .cas_odd_high_half_n_o(cas4[0]),
        .dram_ack_n_o(dram_ack_n_o), .refresh_row_o(refresh_row_o)
    );
    dtr_dram_model dram_model_u (
        .clk_i(clk_i), .maddr_i(mem_addr_o), .ras_n_i(ras_n_o), .cas_n_i(cas4),
        .row_o(row), .col_o(col), .ref_cnt_o(ref_cnt)
    );

    // 25 MHz system clock, cpu clock at half rate
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(negedge clk_i) cpu_clock_i <= ~cpu_clock_i;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one cpu dram access; m is {a19, uds_n, lds_n}
    task automatic access(input logic [17:0] a, input logic [2:0] m, input int hold,
                          output logic [8:0] r, output logic [8:0] c);
        int n;
        @(negedge clk_i);
        rng = xs(rng);
        cpu_addr_i = {4'h0, m[2], a};
        uds_n_i = m[1];
        lds_n_i = m[0];
        rw_i = rng[0];
        exp_q.push_back({rng[0], m[1] | m[2], m[0] | m[2], m[1] | !m[2], m[0] | !m[2]});
        as_n_i = 1'b0;
        dram_sel_n_i = 1'b0;
        n = 0;
        while (dram_ack_n_o !== 1'b0 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        check(n < 40, 1'b1);
        check(ras_n_o, 1'b0);
        repeat (2) @(negedge clk_i);
        check({ras_n_o, dram_ack_n_o}, 2'b10);
        // cpu holds the strobe for the whole access
        repeat (hold) @(negedge clk_i);
        as_n_i = 1'b1;
        dram_sel_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        check({dram_ack_n_o, cas4}, 5'h1f);
        r = row;
        c = col;
    endtask

    // result watcher: each ack fall takes the oldest expected cas pattern
    always @(negedge clk_i) begin
        ack_q <= dram_ack_n_o;
        if (ack_q === 1'b1 && dram_ack_n_o === 1'b0) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0);
            else check({mem_rw_o, cas4}, exp_q.pop_front());
        end
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        summarize();
    end

    initial begin
        logic [17:0] a;
        logic [8:0]  r1;
        logic [8:0]  c1;
        logic [8:0]  r2;
        logic [8:0]  c2;
        int          n;
        int          rc;
        logic [7:0]  k;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        check({ras_n_o, dram_ack_n_o, cas4, mem_addr_o, refresh_row_o}, 24'h7e0000);
        // every strobe mix in both halves, address and its inverse
        for (int i = 0; i < 6; i++) begin
            rng = xs(rng);
            a = rng[17:0];
            access(a, {i[0], ds[i / 2]}, i[0] ? 6 : 0, r1, c1);
            access(~a, {i[0], ds[i / 2]}, 0, r2, c2);
            check({r1 ^ r2, c1 ^ c2}, 18'h3ffff);
        end
        access(18'h0, 3'b000, 0, r1, c1);
        check({r1, c1}, 18'h0);
        // refresh counter spacing
        k = refresh_row_o;
        n = 0;
        while (refresh_row_o === k && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        k = refresh_row_o;
        n = 0;
        while (refresh_row_o === k && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        check(n, 312);
        check(refresh_row_o, k + 8'h01);
        // idle bus: sync strobe high, refresh must wait
        rc = ref_cnt;
        repeat (700) @(negedge clk_i);
        check(ref_cnt, rc);
        exp_wait_i = 1'b1;
        n = 0;
        while (ref_cnt == rc && n < 30) begin
            @(negedge clk_i);
            n++;
        end
        check(ref_cnt, rc + 1);
        check(row[7:0], refresh_row_o);
        exp_wait_i = 1'b0;
        repeat (20) @(negedge clk_i);
        summarize();
    end
endmodule
